// file: logic/prl_pkg.sv
// Constants, encodings and the refill-rate function shared by the rate limiter files.
package prl_pkg;
  localparam int PRL_PORTS = 6;
  localparam int PRL_BUCKETS = 3;
  localparam int PRL_EG_BUCKET = 2;
  localparam int PRL_TYPE_W = 4;
  localparam int PRL_RATE_CNT_W = 8;
  localparam int PRL_LEN_W = 11;
  localparam int PRL_SIZE_W = 16;
  localparam int PRL_INC_W = 22;
  localparam int PRL_CREDIT_W = 48;

  // Core clock rate; one credit unit is 1/(clock/1000) bit, so the per-cycle
  // refill in units equals the bucket bit rate in kb/s.
  localparam longint PRL_CLK_HZ = 125_000_000;
  localparam longint PRL_UNITS_PER_BIT = PRL_CLK_HZ / 1000;
  localparam logic [PRL_CREDIT_W-1:0] PRL_UNITS_PER_BYTE = PRL_CREDIT_W'(8 * PRL_UNITS_PER_BIT);
  localparam logic [PRL_CREDIT_W-1:0] PRL_UNITS_PER_KB =
    PRL_CREDIT_W'(1024 * 8 * PRL_UNITS_PER_BIT);

  // Absolute rate segments: kb/s per count step and segment offsets.
  localparam int PRL_SEG1_KBPS = 64;
  localparam int PRL_SEG2_KBPS = 1000;
  localparam int PRL_SEG3_KBPS = 8000;
  localparam int PRL_SEG2_OFS = 27;
  localparam int PRL_SEG3_OFS = 115;
  localparam int PRL_SEG2_FIRST = 29;
  localparam int PRL_SEG3_FIRST = 128;
  // Speed-scaled kb/s per count step.
  localparam int PRL_SCALE_10M_KBPS = 80;
  localparam int PRL_SCALE_100M_KBPS = 800;
  localparam int PRL_SCALE_1G_KBPS = 8000;

  localparam logic [1:0] PRL_SPEED_10M = 2'h0;
  localparam logic [1:0] PRL_SPEED_100M = 2'h1;
  localparam logic [1:0] PRL_SPEED_1G = 2'h2;

  function automatic logic [PRL_INC_W-1:0] prl_rate_inc(
    input logic [PRL_RATE_CNT_W-1:0] count,
    input logic scaled,
    input logic [1:0] speed
  );
    int r;
    int v;
    r = int'(count);
    v = 0;
    if (scaled) begin
      case (speed)
        PRL_SPEED_10M: v = r * PRL_SCALE_10M_KBPS;
        PRL_SPEED_100M: v = r * PRL_SCALE_100M_KBPS;
        default: v = r * PRL_SCALE_1G_KBPS;
      endcase
    end else if (r < PRL_SEG2_FIRST) begin
      v = r * PRL_SEG1_KBPS;
    end else if (r < PRL_SEG3_FIRST) begin
      v = (r - PRL_SEG2_OFS) * PRL_SEG2_KBPS;
    end else begin
      v = (r - PRL_SEG3_OFS) * PRL_SEG3_KBPS;
    end
    return PRL_INC_W'(v);
  endfunction
endpackage

// file: logic/prl_bucket.sv
// One credit bucket: refill each cycle, cap at the limit, charge per packet.
`timescale 1ns/1ns
module prl_bucket (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [prl_pkg::PRL_INC_W-1:0] refill,
  input wire logic [prl_pkg::PRL_CREDIT_W-1:0] limit,
  input wire logic charge,
  input wire logic [prl_pkg::PRL_CREDIT_W-1:0] amount,
  output logic has_credit
);
  import prl_pkg::*;

  logic signed [PRL_CREDIT_W:0] credit;
  logic signed [PRL_CREDIT_W:0] next_credit;
  logic signed [PRL_CREDIT_W:0] grown;
  logic signed [PRL_CREDIT_W:0] lim_s;
  logic signed [PRL_CREDIT_W:0] inc_s;
  logic signed [PRL_CREDIT_W:0] amt_s;

  // Credit may go negative: a packet admitted on the last scrap of credit
  // leaves a debt, so the long-run admitted rate never beats the refill.
  always_comb begin
    lim_s = signed'({1'b0, limit});
    inc_s = signed'({{(PRL_CREDIT_W + 1 - PRL_INC_W){1'b0}}, refill});
    amt_s = signed'({1'b0, amount});
    grown = credit + inc_s;
    if (grown > lim_s) begin
      grown = lim_s;
    end
    next_credit = grown;
    if (charge) begin
      next_credit = grown - amt_s;
    end
    if (!enable) begin
      next_credit = lim_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      credit <= '0;
    end else begin
      credit <= next_credit;
    end
  end

  assign has_credit = (credit > 0);

  a_credit_capped: assert property (
    @(posedge core_clk) disable iff (!rst_n) 1'b1 |=> credit <= $past(lim_s))
    else $error("bucket credit exceeds its size");

  a_credit_grows: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (enable && !charge && (credit + inc_s <= lim_s)) |=> credit == $past(credit) + $past(inc_s))
    else $error("bucket credit did not grow by the refill");

  a_charge_taken: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (enable && charge && amount != '0) |=> credit < $past(credit) + $past(inc_s))
    else $error("bucket credit not reduced by a packet");

  a_idle_full: assert property (
    @(posedge core_clk) disable iff (!rst_n) !enable [*2] |-> credit == $past(lim_s))
    else $error("disabled bucket not held at its size");
endmodule // prl_bucket

// file: logic/port_rate_limiter.sv
// Per-port ingress two-bucket policer and egress one-bucket rate limiter.
`timescale 1ns/1ns
// Summary of operation
// - Every bucket gains credit each cycle at its configured rate.
// - An admitted packet of a watched type subtracts credit from the bucket.
// - Credit keeps growing when idle but stops at the programmed bucket size.
// - After draining, governed traffic passes no faster than the refill rate.
// - Excess ingress packets are dropped or held by flow control, per drop mode; excess egress packets are always held.
// - With no credit left, governed packets on that port are refused.
// - Each port has ingress buckets zero and one with own type masks.
// - A bucket may watch many types; one type may hit both buckets.
// - Rate count and size are set separately per bucket per port.
// - Each port has its own suppression enable; disabled ports pass freely.
// - Egress limiting covers all transmitted traffic regardless of type.
// - Egress uses exactly one credit bucket per port.
// - The egress bucket always uses absolute rate mode.
// - Rate scaling select is chip-wide; rate counts are per port.
// - Absolute rate uses three count segments with offsets 27 and 115.
// - Scaled rate is count times 8 Mb/s over 100, 10 or 1 by speed.
module port_rate_limiter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rate_scale_mode,
  input wire logic drop_mode,
  input wire logic [1:0] link_speed [prl_pkg::PRL_PORTS],
  input wire logic supp_en [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_TYPE_W-1:0] type_mask_b0 [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_TYPE_W-1:0] type_mask_b1 [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_RATE_CNT_W-1:0] rate_count_value_b0 [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_RATE_CNT_W-1:0] rate_count_value_b1 [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_SIZE_W-1:0] size_kb_b0 [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_SIZE_W-1:0] size_kb_b1 [prl_pkg::PRL_PORTS],
  input wire logic tx_limit_en [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_RATE_CNT_W-1:0] rate_count_value_tx [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_SIZE_W-1:0] size_kb_tx [prl_pkg::PRL_PORTS],
  input wire logic rx_valid [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_TYPE_W-1:0] rx_type [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_LEN_W-1:0] rx_len [prl_pkg::PRL_PORTS],
  output logic rx_ready [prl_pkg::PRL_PORTS],
  output logic rx_drop [prl_pkg::PRL_PORTS],
  input wire logic tx_valid [prl_pkg::PRL_PORTS],
  input wire logic [prl_pkg::PRL_LEN_W-1:0] tx_len [prl_pkg::PRL_PORTS],
  output logic tx_ready [prl_pkg::PRL_PORTS]
);
  import prl_pkg::*;

  logic bkt_en [PRL_PORTS][PRL_BUCKETS];
  logic [PRL_INC_W-1:0] bkt_inc [PRL_PORTS][PRL_BUCKETS];
  logic [PRL_CREDIT_W-1:0] bkt_lim [PRL_PORTS][PRL_BUCKETS];
  logic bkt_chg [PRL_PORTS][PRL_BUCKETS];
  logic [PRL_CREDIT_W-1:0] bkt_amt [PRL_PORTS][PRL_BUCKETS];
  logic bkt_ok [PRL_PORTS][PRL_BUCKETS];

  genvar p;
  genvar b;
  generate
    for (p = 0; p < PRL_PORTS; p++) begin : g_port
      logic hit0;
      logic hit1;
      logic blocked;
      logic admit;
      logic tx_take;
      logic next_drop;
      logic drop_q;
      logic [PRL_CREDIT_W-1:0] rx_amt;
      logic [PRL_CREDIT_W-1:0] tx_amt;

      always_comb begin
        hit0 = supp_en[p] && ((rx_type[p] & type_mask_b0[p]) != '0);
        hit1 = supp_en[p] && ((rx_type[p] & type_mask_b1[p]) != '0);
        blocked = (hit0 && !bkt_ok[p][0]) || (hit1 && !bkt_ok[p][1]);
        if (drop_mode) begin
          rx_ready[p] = 1'b1;
        end else begin
          rx_ready[p] = !blocked;
        end
        admit = rx_valid[p] && !blocked;
        next_drop = rx_valid[p] && blocked && drop_mode;
        tx_ready[p] = !tx_limit_en[p] || bkt_ok[p][PRL_EG_BUCKET];
        tx_take = tx_valid[p] && tx_limit_en[p] && bkt_ok[p][PRL_EG_BUCKET];
        rx_amt = PRL_CREDIT_W'(PRL_CREDIT_W'(rx_len[p]) * PRL_UNITS_PER_BYTE);
        tx_amt = PRL_CREDIT_W'(PRL_CREDIT_W'(tx_len[p]) * PRL_UNITS_PER_BYTE);
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          drop_q <= 1'b0;
        end else begin
          drop_q <= next_drop;
        end
      end
      assign rx_drop[p] = drop_q;

      always_comb begin
        bkt_en[p][0] = supp_en[p];
        bkt_en[p][1] = supp_en[p];
        bkt_inc[p][0] = prl_rate_inc(rate_count_value_b0[p], rate_scale_mode, link_speed[p]);
        bkt_inc[p][1] = prl_rate_inc(rate_count_value_b1[p], rate_scale_mode, link_speed[p]);
        bkt_lim[p][0] = PRL_CREDIT_W'(PRL_CREDIT_W'(size_kb_b0[p]) * PRL_UNITS_PER_KB);
        bkt_lim[p][1] = PRL_CREDIT_W'(PRL_CREDIT_W'(size_kb_b1[p]) * PRL_UNITS_PER_KB);
        bkt_chg[p][0] = admit && hit0;
        bkt_chg[p][1] = admit && hit1;
        bkt_amt[p][0] = rx_amt;
        bkt_amt[p][1] = rx_amt;
        bkt_en[p][PRL_EG_BUCKET] = tx_limit_en[p];
        bkt_inc[p][PRL_EG_BUCKET] = prl_rate_inc(rate_count_value_tx[p], 1'b0, link_speed[p]);
        bkt_lim[p][PRL_EG_BUCKET] = PRL_CREDIT_W'(PRL_CREDIT_W'(size_kb_tx[p]) * PRL_UNITS_PER_KB);
        bkt_chg[p][PRL_EG_BUCKET] = tx_take;
        bkt_amt[p][PRL_EG_BUCKET] = tx_amt;
      end

      for (b = 0; b < PRL_BUCKETS; b++) begin : g_bkt
        prl_bucket u_bucket (
          .core_clk(core_clk),
          .rst_n(rst_n),
          .enable(bkt_en[p][b]),
          .refill(bkt_inc[p][b]),
          .limit(bkt_lim[p][b]),
          .charge(bkt_chg[p][b]),
          .amount(bkt_amt[p][b]),
          .has_credit(bkt_ok[p][b])
        );
      end

      a_drop_cause: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rx_drop[p] |-> $past(rx_valid[p] && blocked && drop_mode))
        else $error("packet dropped without an empty governing bucket");

      a_hold_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!drop_mode && blocked) |-> !rx_ready[p] && !bkt_chg[p][0] && !bkt_chg[p][1])
        else $error("governed packet accepted with no credit");

      a_unpoliced_pass: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !supp_en[p] |-> rx_ready[p] && !blocked ##1 !rx_drop[p])
        else $error("unpoliced port refused or dropped a packet");

      a_both_charged: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_valid[p] && !blocked && hit0 && hit1) |-> bkt_chg[p][0] && bkt_chg[p][1])
        else $error("shared packet type not charged to both buckets");

      a_egress_abs: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bkt_inc[p][PRL_EG_BUCKET] == prl_rate_inc(rate_count_value_tx[p], 1'b0, 2'h0))
        else $error("egress refill depends on scaling or speed");

      a_egress_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (tx_limit_en[p] && !bkt_ok[p][PRL_EG_BUCKET]) |-> !tx_ready[p] && !tx_take)
        else $error("egress packet sent with no credit");
    end
  endgenerate
endmodule // port_rate_limiter

// file: bench/prl_port_model.sv
// Far-side port model: keeps one packet offered and times each accept.
`timescale 1ns/1ns
module prl_port_model (
  input wire logic core_clk,
  input wire logic offer,
  input wire logic ready,
  output logic valid,
  output int gap,
  output int takes
);
  int since;
  // A MAC holds its frame unchanged until the block takes it.
  assign valid = offer;
  always_ff @(posedge core_clk) begin
    if (!offer) begin
      since <= 0;
      takes <= 0;
    end else if (ready) begin
      gap <= since;
      takes <= takes + 1;
      since <= 1;
    end else begin
      since <= since + 1;
    end
  end
endmodule // prl_port_model

// file: bench/test_port_rate_limiter.sv
// Self-checking bench for the port rate limiter.
`timescale 1ns/1ns
module test_port_rate_limiter;
  import prl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rate_scale_mode, drop_mode, rx_offer = 1'b0, tx_offer = 1'b0, v_rx, v_tx;
  logic [1:0] link_speed [PRL_PORTS];
  logic supp_en [PRL_PORTS], tx_limit_en [PRL_PORTS], rx_valid [PRL_PORTS];
  logic tx_valid [PRL_PORTS], rx_ready [PRL_PORTS], rx_drop [PRL_PORTS], tx_ready [PRL_PORTS];
  logic [PRL_TYPE_W-1:0] type_mask_b0 [PRL_PORTS], type_mask_b1 [PRL_PORTS], rx_type [PRL_PORTS];
  logic [PRL_RATE_CNT_W-1:0] rate_count_value_b0 [PRL_PORTS], rate_count_value_b1 [PRL_PORTS];
  logic [PRL_RATE_CNT_W-1:0] rate_count_value_tx [PRL_PORTS];
  logic [PRL_SIZE_W-1:0] size_kb_b0 [PRL_PORTS], size_kb_b1 [PRL_PORTS], size_kb_tx [PRL_PORTS];
  logic [PRL_LEN_W-1:0] rx_len [PRL_PORTS], tx_len [PRL_PORTS];
  int rx_gap, rx_takes, tx_gap, tx_takes, d, rlen = 19;
  int miscompares = 0;
  int total_checks = 0;

  port_rate_limiter u_dut (.core_clk, .rst_n, .rate_scale_mode, .drop_mode, .link_speed,
    .supp_en, .type_mask_b0, .type_mask_b1, .rate_count_value_b0, .rate_count_value_b1,
    .size_kb_b0, .size_kb_b1, .tx_limit_en, .rate_count_value_tx, .size_kb_tx, .rx_valid,
    .rx_type, .rx_len, .rx_ready, .rx_drop, .tx_valid, .tx_len, .tx_ready);
  prl_port_model u_rx (.core_clk, .offer(rx_offer), .ready(rx_ready[0]), .valid(v_rx),
    .gap(rx_gap), .takes(rx_takes));
  prl_port_model u_tx (.core_clk, .offer(tx_offer), .ready(tx_ready[0]), .valid(v_tx),
    .gap(tx_gap), .takes(tx_takes));

  // Only port 0 carries traffic; the other ports stay idle.
  always_comb begin
    for (int i = 0; i < PRL_PORTS; i++) begin
      rx_valid[i] = (i == 0) && v_rx;
      tx_valid[i] = (i == 0) && v_tx;
    end
  end

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Configure all ports alike, reset, then time accepts on port 0 when exp is nonzero.
  task automatic go(input logic sm, input logic [1:0] sp, input logic se,
      input logic [3:0] m0, input logic [3:0] m1, input logic [7:0] r0, input logic [7:0] r1,
      input int len, input int sz, input logic tx, input int exp);
    // Inputs move only on a rising edge.
    @(posedge core_clk);
    rate_scale_mode <= sm;
    drop_mode <= 1'b0;
    rx_offer <= 1'b0;
    tx_offer <= 1'b0;
    rst_n <= 1'b0;
    for (int i = 0; i < PRL_PORTS; i++) begin
      link_speed[i] <= sp;
      supp_en[i] <= se;
      tx_limit_en[i] <= 1'b1;
      type_mask_b0[i] <= m0;
      type_mask_b1[i] <= m1;
      rx_type[i] <= 4'h1;
      rate_count_value_b0[i] <= r0;
      rate_count_value_b1[i] <= r1;
      rate_count_value_tx[i] <= r0;
      size_kb_b0[i] <= PRL_SIZE_W'(sz);
      size_kb_b1[i] <= PRL_SIZE_W'(sz);
      size_kb_tx[i] <= PRL_SIZE_W'(sz);
      rx_len[i] <= PRL_LEN_W'(len);
      tx_len[i] <= PRL_LEN_W'(len);
    end
    repeat (rlen) @(posedge core_clk);
    rlen = 2;
    #1 check("rst_ready", rx_ready[0], !(se && (m0[0] || m1[0])));
    check("rst_ready_last", rx_ready[PRL_PORTS-1], !(se && (m0[0] || m1[0])));
    check("rst_tx_ready", tx_ready[0], 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    if (exp > 0) begin
      if (tx) tx_offer <= 1'b1;
      else rx_offer <= 1'b1;
      for (int n = 0; n < 40000; n++) begin
        @(posedge core_clk);
        if ((tx ? tx_takes : rx_takes) >= 4) break;
      end
      #1 check("gap", tx ? tx_gap : rx_gap, exp);
      check("takes", (tx ? tx_takes : rx_takes) >= 4, 1);
      $display("test end: expected gap %0d", exp);
    end
  endtask

  initial begin
    go(0, 2, 1, 1, 0, 128, 128, 13, 16'hffff, 0, 125);
    go(0, 2, 1, 1, 0, 31, 31, 1, 16'hffff, 0, 250);
    go(0, 2, 1, 1, 0, 5, 5, 1, 16'hffff, 0, 3125);
    go(1, 2, 1, 1, 0, 13, 13, 13, 16'hffff, 0, 125);
    go(1, 1, 1, 1, 0, 130, 130, 13, 16'hffff, 0, 125);
    go(1, 0, 1, 1, 0, 200, 200, 2, 16'hffff, 0, 125);
    go(0, 2, 1, 0, 1, 5, 128, 13, 16'hffff, 0, 125);
    go(0, 2, 1, 1, 1, 255, 31, 1, 16'hffff, 0, 250);
    go(0, 2, 1, 1, 1, 31, 255, 1, 16'hffff, 0, 250);
    go(0, 2, 1, 2, 4, 5, 5, 13, 16'hffff, 0, 1);
    go(0, 2, 0, 1, 1, 5, 5, 13, 16'hffff, 0, 1);
    go(1, 0, 1, 1, 0, 128, 128, 13, 16'hffff, 1, 125);
    go(0, 2, 1, 1, 0, 255, 255, 2000, 1, 0, 0);
    repeat (3000) @(posedge core_clk);
    rx_offer <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check("burst", rx_takes, 1);
    $display("test end: bucket cap");
    go(0, 2, 1, 1, 0, 128, 128, 13, 16'hffff, 0, 0);
    drop_mode <= 1'b1;
    rx_offer <= 1'b1;
    repeat (400) @(posedge core_clk);
    d = 0;
    repeat (250) begin
      @(negedge core_clk);
      if (rx_drop[0] === 1'b1) d++;
    end
    check("drops", d, 248);
    check("drop_ready", rx_ready[0], 1);
    $display("test end: drop mode");
    finish_test;
  end

  initial begin
    #600000;
    miscompares++;
    finish_test;
  end
endmodule // test_port_rate_limiter
